/* verilog/socket_present_state.sv */
// Socket present-state register with force-event writes and socket event flags
`timescale 1ns/1ps
`include "socket_state_consts.svh"
module socket_present_state #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic host_bus_reset_n,
  input wire logic pme_enable,
  input wire logic high_volt_disable,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic card_irq_pin,
  input wire logic detect_one_pin,
  input wire logic detect_two_pin,
  input wire logic card_status_pin,
  input wire logic socket_power_good,
  input wire logic supply_req,
  input wire logic supply_req_invalid,
  input wire logic removal_loss,
  input wire logic probe_done,
  input wire logic probe_wide,
  input wire logic probe_narrow,
  input wire logic probe_unknown,
  input wire logic [3:0] probe_volt,
  output logic probe_start,
  output logic power_ctrl_disable,
  output logic [3:0] event_flags
);

  // Two flops are the least that lets a metastable sample settle
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least 2");
  end

  // Chains start at the idle levels so reset release shows no false insertion
  localparam logic [`LINE_N-1:0] LINE_IDLE_LEVELS = `LINE_IDLE;

  socket_state_pkg::probe_state_t state;

  logic [`LINE_N-1:0] pins;
  logic [`LINE_N-1:0] synced;
  logic ctx_clr;
  logic wr_force;
  logic wr_event;
  logic card_in;
  logic card_in_q;
  logic start_probe;
  logic sts_event;
  logic [`EV_W-1:0] ev_set;

  logic sock_cap_future_y;
  logic sock_cap_future_x;
  logic sock_cap_low_volt;
  logic sock_cap_high_volt;
  logic [3:0] card_sup;
  logic invalid_supply_request;
  logic removal_loss_flag;
  logic unrecognized_card_flag;
  logic card_irq_level;
  logic wide_card_present;
  logic narrow_card_present;
  logic socket_powered;
  logic detect_two_level;
  logic detect_one_level;
  logic card_status_level;
  logic [31:0] state_word;

  assign pins[`LINE_IRQ] = card_irq_pin;
  assign pins[`LINE_DET1] = detect_one_pin;
  assign pins[`LINE_DET2] = detect_two_pin;
  assign pins[`LINE_STS] = card_status_pin;

  genvar gi;
  generate
    for (gi = 0; gi < `LINE_N; gi = gi + 1) begin : g_sync
      logic [SYNC_STAGES-1:0] chain;
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          chain <= {SYNC_STAGES{LINE_IDLE_LEVELS[gi]}};
        end else begin
          chain <= {chain[SYNC_STAGES-2:0], pins[gi]};
        end
      end
      assign synced[gi] = chain[SYNC_STAGES-1];
    end
  endgenerate

  // host reset clears context only without power management
  assign ctx_clr = !host_bus_reset_n && !pme_enable;
  // only event and force offsets accept writes
  assign wr_force = wr && (addr == `OFF_FORCE);
  assign wr_event = wr && (addr == `OFF_EVENT);
  assign card_in = !synced[`LINE_DET1] && !synced[`LINE_DET2];
  assign start_probe = (state == socket_state_pkg::PROBE_IDLE) &&
                       ((card_in && !card_in_q) || (wr_force && wdata[`B_CVSTEST]));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      card_in_q <= 1'b0;
    end else begin
      card_in_q <= card_in;
    end
  end

  // Interrogation sequencer; results come from the identification logic
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= socket_state_pkg::PROBE_IDLE;
      probe_start <= 1'b0;
    end else begin
      probe_start <= start_probe;
      unique case (state)
        socket_state_pkg::PROBE_IDLE: begin
          if (start_probe) begin
            state <= socket_state_pkg::PROBE_BUSY;
          end
        end
        socket_state_pkg::PROBE_BUSY: begin
          if (probe_done) begin
            state <= socket_state_pkg::PROBE_IDLE;
          end
        end
      endcase
    end
  end

  // overrides stick until reset; writes of 0 do not undo them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sock_cap_future_y <= 1'b0;
      sock_cap_future_x <= 1'b0;
      sock_cap_low_volt <= 1'b1;
    end else if (wr_force) begin
      sock_cap_future_y <= sock_cap_future_y | wdata[`B_CAP_Y];
      sock_cap_future_x <= sock_cap_future_x | wdata[`B_CAP_X];
      sock_cap_low_volt <= sock_cap_low_volt & ~wdata[`B_CAP_LOW];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sock_cap_high_volt <= 1'b1;
    end else begin
      sock_cap_high_volt <= !high_volt_disable;
    end
  end

  // card fields: interrogation result or forced write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      card_sup <= `CARD_V_RST;
      wide_card_present <= 1'b0;
      narrow_card_present <= 1'b0;
    end else if (ctx_clr) begin
      card_sup <= `CARD_V_RST;
      wide_card_present <= 1'b0;
      narrow_card_present <= 1'b0;
    end else if (wr_force) begin
      card_sup <= wdata[`B_CARD_HI:`B_CARD_LO];
      wide_card_present <= wdata[`B_WIDE];
      narrow_card_present <= wdata[`B_NARROW];
    end else if (state == socket_state_pkg::PROBE_BUSY && probe_done && !probe_unknown) begin
      card_sup <= probe_volt;
      wide_card_present <= probe_wide;
      narrow_card_present <= probe_narrow;
    end
  end

  // Forcing a voltage holds power control off until a forced write with the B_CVSTEST bit set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      power_ctrl_disable <= 1'b0;
    end else if (wr_force && wdata[`B_CVSTEST]) begin
      power_ctrl_disable <= 1'b0;
    end else if (wr_force && (|wdata[`B_CARD_HI:`B_CARD_LO])) begin
      power_ctrl_disable <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      invalid_supply_request <= 1'b0;
    end else if (ctx_clr) begin
      invalid_supply_request <= 1'b0;
    end else if (wr_force) begin
      invalid_supply_request <= wdata[`B_BADV];
    end else if (supply_req) begin
      invalid_supply_request <= supply_req_invalid;
    end
  end

  // loss flag; the next interrogation starts a clean slate
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      removal_loss_flag <= 1'b0;
    end else if (ctx_clr) begin
      removal_loss_flag <= 1'b0;
    end else if (wr_force) begin
      removal_loss_flag <= wdata[`B_LOST];
    end else if (removal_loss) begin
      removal_loss_flag <= 1'b1;
    end else if (start_probe) begin
      removal_loss_flag <= 1'b0;
    end
  end

  // unknown card flag, cleared by a valid card probe or a context clear, loaded by a forced write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unrecognized_card_flag <= 1'b0;
    end else if (ctx_clr) begin
      unrecognized_card_flag <= 1'b0;
    end else if (wr_force) begin
      unrecognized_card_flag <= wdata[`B_NOTCARD];
    end else if (state == socket_state_pkg::PROBE_BUSY && probe_done) begin
      unrecognized_card_flag <= probe_unknown;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      socket_powered <= 1'b0;
    end else if (ctx_clr) begin
      socket_powered <= 1'b0;
    end else begin
      socket_powered <= socket_power_good;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      card_irq_level <= 1'b0;
      card_status_level <= 1'b0;
    end else begin
      card_irq_level <= synced[`LINE_IRQ];
      card_status_level <= synced[`LINE_STS];
    end
  end

  // detect levels frozen while a card is identified
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      detect_one_level <= LINE_IDLE_LEVELS[`LINE_DET1];
      detect_two_level <= LINE_IDLE_LEVELS[`LINE_DET2];
    end else if (ctx_clr) begin
      detect_one_level <= 1'b0;
      detect_two_level <= 1'b0;
    end else if (state == socket_state_pkg::PROBE_IDLE) begin
      detect_one_level <= synced[`LINE_DET1];
      detect_two_level <= synced[`LINE_DET2];
    end
  end

  // wide cards flag rising edges only, others both edges
  assign sts_event = wide_card_present ? (synced[`LINE_STS] && !card_status_level)
                                       : (synced[`LINE_STS] != card_status_level);

  // change of power, detect or status bits, or a forced write, sets the event flags
  always_comb begin
    ev_set = `EV_RST;
    ev_set[`B_PWR] = socket_powered != socket_power_good;
    ev_set[`B_DET2] = (state == socket_state_pkg::PROBE_IDLE) &&
                      (detect_two_level != synced[`LINE_DET2]);
    ev_set[`B_DET1] = (state == socket_state_pkg::PROBE_IDLE) &&
                      (detect_one_level != synced[`LINE_DET1]);
    ev_set[`B_STS] = sts_event;
    if (wr_force) begin
      ev_set = ev_set | wdata[`EV_W-1:0];
    end
  end

  // A set in the clearing cycle wins over the write-one clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_flags <= `EV_RST;
    end else if (ctx_clr) begin
      event_flags <= `EV_RST;
    end else if (wr_event) begin
      event_flags <= (event_flags & ~wdata[`EV_W-1:0]) | ev_set;
    end else begin
      event_flags <= event_flags | ev_set;
    end
  end

  // status word assembly; unnamed bits stay zero
  always_comb begin
    state_word = `WORD_ZERO;
    state_word[`B_CAP_Y] = sock_cap_future_y;
    state_word[`B_CAP_X] = sock_cap_future_x;
    state_word[`B_CAP_LOW] = sock_cap_low_volt;
    state_word[`B_CAP_HIGH] = sock_cap_high_volt;
    state_word[`B_CARD_HI:`B_CARD_LO] = card_sup;
    state_word[`B_BADV] = invalid_supply_request;
    state_word[`B_LOST] = removal_loss_flag;
    state_word[`B_NOTCARD] = unrecognized_card_flag;
    state_word[`B_IRQ] = card_irq_level;
    state_word[`B_WIDE] = wide_card_present;
    state_word[`B_NARROW] = narrow_card_present;
    state_word[`B_PWR] = socket_powered;
    state_word[`B_DET2] = detect_two_level;
    state_word[`B_DET1] = detect_one_level;
    state_word[`B_STS] = card_status_level;
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= `WORD_ZERO;
    end else if (rd) begin
      if (addr == `OFF_STATE) begin
        rdata <= state_word;
      end else if (addr == `OFF_EVENT) begin
        rdata <= {{(32-`EV_W){1'b0}}, event_flags};
      end else begin
        rdata <= `WORD_ZERO;
      end
    end else begin
      rdata <= `WORD_ZERO;
    end
  end

endmodule : socket_present_state

/* verilog/socket_state_consts.svh */
// Offsets, field positions and reset values of the socket status block
`ifndef SOCKET_STATE_CONSTS_SVH
`define SOCKET_STATE_CONSTS_SVH
`define OFF_EVENT 8'h00
`define OFF_STATE 8'h08
`define OFF_FORCE 8'h0C
`define B_CAP_Y 31
`define B_CAP_X 30
`define B_CAP_LOW 29
`define B_CAP_HIGH 28
`define B_CVSTEST 14
`define B_CARD_HI 13
`define B_CARD_LO 10
`define B_BADV 9
`define B_LOST 8
`define B_NOTCARD 7
`define B_IRQ 6
`define B_WIDE 5
`define B_NARROW 4
`define B_PWR 3
`define B_DET2 2
`define B_DET1 1
`define B_STS 0
`define EV_W 4
`define LINE_IRQ 0
`define LINE_DET1 1
`define LINE_DET2 2
`define LINE_STS 3
`define LINE_N 4
// Detect lines idle high with no card; the others idle low
`define LINE_IDLE 4'h6
`define CARD_V_RST 4'h0
`define EV_RST 4'h0
`define WORD_ZERO 32'h00000000
`endif

/* verilog/socket_state_pkg.sv */
// Types shared by the socket status block
package socket_state_pkg;
  typedef enum logic [0:0] {
    PROBE_IDLE = 1'b0,
    PROBE_BUSY = 1'b1
  } probe_state_t;
endpackage : socket_state_pkg

/* sim/socket_present_state_props.sv */
// Port-level checker for the socket present-state block
`timescale 1ns/1ps
module socket_present_state_props #(
  parameter int SYNC_STAGES = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic host_bus_reset_n,
  input wire logic pme_enable,
  input wire logic high_volt_disable,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic card_irq_pin,
  input wire logic socket_power_good,
  input wire logic probe_start,
  input wire logic power_ctrl_disable,
  input wire logic [3:0] event_flags
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  // Five stable samples cover the default synchronizer plus output stage
  sequence irq_settled;
    $stable(card_irq_pin) [*5];
  endsequence
  sequence state_read;
    rd && addr == 8'h08;
  endsequence
  a_read_idle_zero: assert property (!rd |=> rdata == 32'h00000000)
    else $error("rdata not zero outside a read");
  a_rsvd_bits_zero: assert property (state_read |=> rdata[27:14] == 14'h0000)
    else $error("reserved status bits not zero");
  a_high_volt_cap: assert property (state_read ##0 $stable(high_volt_disable)
    |=> rdata[28] == !$past(high_volt_disable))
    else $error("high-voltage capability bit wrong");
  a_irq_level_live: assert property (irq_settled ##0 state_read
    |=> rdata[6] == $past(card_irq_pin))
    else $error("interrupt line level not reported");
  a_probe_one_pulse: assert property (probe_start |=> !probe_start)
    else $error("probe start longer than one cycle");
  a_force_pwr_off: assert property (wr && addr == 8'h0C && (|wdata[13:10]) && !wdata[14]
    |=> power_ctrl_disable)
    else $error("forced card voltage left power control enabled");
  a_power_event_set: assert property (disable iff (!rstn || !host_bus_reset_n)
    $changed(socket_power_good) |-> ##[1:4] event_flags[3])
    else $error("power change did not set its event flag");
  a_power_event_hold: assert property (event_flags[3] && !(wr && addr == 8'h00)
    && host_bus_reset_n |=> event_flags[3])
    else $error("power event flag dropped without a clear");
  a_context_clear: assert property (!host_bus_reset_n && !pme_enable
    |=> event_flags == 4'h0)
    else $error("host reset did not clear event flags");
endmodule : socket_present_state_props

/* sim/card_model.sv */
// Inserted card model: detect lines and interrogation answers
`timescale 1ns/1ps
module card_model (
  input wire logic clk,
  input wire logic probe_start,
  input wire logic inserted,
  input wire logic wide,
  input wire logic unknown,
  input wire logic slow,
  input wire logic [3:0] volt,
  output logic detect_one_pin,
  output logic detect_two_pin,
  output logic probe_done,
  output logic probe_wide,
  output logic probe_narrow,
  output logic probe_unknown,
  output logic [3:0] probe_volt
);
  int cnt = 0;
  assign detect_one_pin = !inserted;
  assign detect_two_pin = !inserted;
  initial begin
    probe_done = 1'b0;
    {probe_wide, probe_narrow, probe_unknown, probe_volt} = 7'h00;
  end
  // Results are only meaningful with probe_done, so they churn otherwise
  always @(posedge clk) begin
    probe_done <= cnt == 1;
    if (cnt == 1) begin
      {probe_wide, probe_narrow, probe_unknown, probe_volt} <= {wide, !wide, unknown, volt};
    end else begin
      {probe_wide, probe_narrow, probe_unknown, probe_volt} <=
        ~{probe_wide, probe_narrow, probe_unknown, probe_volt};
    end
    if (probe_start) begin
      cnt <= slow ? 12 : 2;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule : card_model

/* sim/test_socket_present_state.sv */
// Self-checking bench for the socket present-state block
`timescale 1ns/1ps
module test_socket_present_state;
  logic clk = 1'b0, rstn = 1'b0, hbr_n = 1'b1, pme = 1'b0, hvd = 1'b0;
  logic wr = 1'b0, rd = 1'b0, irq = 1'b1, sts = 1'b0, pg = 1'b0, sreq = 1'b0;
  logic sinv = 1'b0, rloss = 1'b0, ins = 1'b0, wide = 1'b1, unk = 1'b0, slow = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] volt = 4'h5;
  logic [31:0] rdata;
  logic [3:0] pvolt, ev;
  logic det1, det2, pdone, pwide, pnarrow, punk, pstart, pcd;
  int failures = 0, n_compared = 0;
  always #4 clk = ~clk;
  socket_present_state dut_u (.clk(clk), .rstn(rstn), .host_bus_reset_n(hbr_n),
    .pme_enable(pme), .high_volt_disable(hvd), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .card_irq_pin(irq), .detect_one_pin(det1),
    .detect_two_pin(det2), .card_status_pin(sts), .socket_power_good(pg),
    .supply_req(sreq), .supply_req_invalid(sinv), .removal_loss(rloss),
    .probe_done(pdone), .probe_wide(pwide), .probe_narrow(pnarrow),
    .probe_unknown(punk), .probe_volt(pvolt), .probe_start(pstart),
    .power_ctrl_disable(pcd), .event_flags(ev));
  card_model card_u (.clk(clk), .probe_start(pstart), .inserted(ins), .wide(wide),
    .unknown(unk), .slow(slow), .volt(volt), .detect_one_pin(det1),
    .detect_two_pin(det2), .probe_done(pdone), .probe_wide(pwide),
    .probe_narrow(pnarrow), .probe_unknown(punk), .probe_volt(pvolt));
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr32
  task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp($sformatf("reg %h", a), e, rdata & m);
  endtask : chk
  task automatic wait_probe();
    for (int i = 0; i < 200 && pdone !== 1'b1; i++) @(posedge clk);
    if (pdone !== 1'b1) begin
      cmp("probe_done", 32'h00000001, {31'h0, pdone});
      report_and_stop();
    end
    repeat (5) @(posedge clk);
  endtask : wait_probe
  // Status event: rise always counts, fall only when no wide card is present
  task automatic sts_edges(input logic [31:0] fall_ev);
    sts <= 1'b1;
    repeat (5) @(posedge clk);
    chk(8'h00, 32'h00000001, 32'h00000001);
    chk(8'h08, 32'h00000001, 32'h00000001);
    wr32(8'h00, 32'h0000000F);
    sts <= 1'b0;
    repeat (5) @(posedge clk);
    chk(8'h00, 32'h00000001, fall_ev);
  endtask : sts_edges
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    chk(8'h08, 32'hFFFFFFFF, 32'h30000046);
    wr32(8'h08, 32'hFFFFFFFF);
    chk(8'h08, 32'hFFFFFFFF, 32'h30000046);
    chk(8'h04, 32'hFFFFFFFF, 32'h00000000);
    {hvd, irq} <= 2'b10;
    repeat (2) @(posedge clk);
    chk(8'h08, 32'h10000040, 32'h00000000);
    {hvd, irq} <= 2'b01;
    ins <= 1'b1;
    wait_probe();
    chk(8'h08, 32'h00003C3E, 32'h00001420);
    chk(8'h00, 32'h0000000F, 32'h00000006);
    sts_edges(32'h00000000);
    pg <= 1'b1;
    repeat (4) @(posedge clk);
    chk(8'h08, 32'h00000008, 32'h00000008);
    chk(8'h00, 32'h00000008, 32'h00000008);
    cmp("event_flags", 32'h00000008, {28'h0, ev});
    {sreq, sinv, rloss} <= 3'b111;
    @(posedge clk);
    {sreq, rloss} <= 2'b00;
    chk(8'h08, 32'h00000300, 32'h00000300);
    {unk, slow} <= 2'b11;
    wr32(8'h0C, 32'h00005620);
    wait_probe();
    chk(8'h08, 32'h00003FB0, 32'h000016A0);
    wr32(8'h0C, 32'h00003C10);
    chk(8'h08, 32'h00003FB0, 32'h00003C10);
    cmp("power_ctrl_disable", 32'h00000001, {31'h0, pcd});
    sts_edges(32'h00000001);
    wr32(8'h0C, 32'hE0003C10);
    chk(8'h08, 32'hF0000000, 32'hD0000000);
    {pme, hbr_n} <= 2'b10;
    @(posedge clk);
    hbr_n <= 1'b1;
    chk(8'h08, 32'h00003FB0, 32'h00003C10);
    {pme, hbr_n} <= 2'b00;
    @(posedge clk);
    hbr_n <= 1'b1;
    chk(8'h08, 32'h00003FB0, 32'h00000000);
    report_and_stop();
  end
endmodule : test_socket_present_state
bind socket_present_state socket_present_state_props #(.SYNC_STAGES(SYNC_STAGES)) chk_u (
  .clk(clk), .rstn(rstn), .host_bus_reset_n(host_bus_reset_n), .pme_enable(pme_enable),
  .high_volt_disable(high_volt_disable), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .card_irq_pin(card_irq_pin), .socket_power_good(socket_power_good),
  .probe_start(probe_start), .power_ctrl_disable(power_ctrl_disable),
  .event_flags(event_flags));
